// [hw/timer_ccv_regs.sv]
/*
 * AXI4-Lite register block for three capture/compare channels, the burst
 * configuration and window, and the equal-write ignore option.
 * assumes the counter, capture and update logic lie outside and give pulses.
 */
`timescale 1ns/1ns
// Behaviour
// - an input channel holds the counter value latched at its last capture and is read-only.
// - an output channel's compare value, loaded from its value, is the one compared against the counter.
// - with shadowing on, a written compare value goes active only at an update event.
// - a burst makes count plus one accesses, with the count kept between 0 and 0x11.
// - the start field selects the register reached by the first window access.
// - the window access at hardware index 1 reaches the register one word past the start.
// - each window access goes to the word at start plus a hardware index running 0 to count.
// - with the ignore bit set, a value write equal to the stored value is dropped.
// - a channel with nonzero capture source selection ignores software value writes.
module timer_ccv_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// axi write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// timer core
	input wire logic update_event,
	input wire logic [2:0] capture_event,
	input wire logic [15:0] counter_value,
	output logic [15:0] ch1_compare_reg,
	output logic [15:0] ch2_compare_reg,
	output logic [15:0] ch3_compare_reg
);
	import timer_ccv_pkg::*;

	logic [4:0] burst_count_reg;
	logic [4:0] burst_start_index_reg;
	logic [4:0] burst_index_reg;
	logic equal_write_ignore_reg;
	logic [5:0] capture_source_select_reg;
	logic [2:0] shadow_enable_reg;
	logic [7:0] aw_addr_reg;
	logic aw_held_reg;
	logic [31:0] w_data_reg;
	logic w_held_reg;
	logic [15:0] value_bus [3];
	logic [15:0] compare_bus [3];

	// word address to byte address of a redirected window access
	function automatic logic [7:0] window_target(input logic [4:0] start, input logic [4:0] idx);
		window_target = {1'b0, 7'(start + idx)} << 2;
	endfunction

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			ch1_value_offset: r = {16'h0000, value_bus[0]};
			ch2_value_offset: r = {16'h0000, value_bus[1]};
			ch3_value_offset: r = {16'h0000, value_bus[2]};
			burst_config_offset: r = {19'h0, burst_count_reg, 3'h0, burst_start_index_reg};
			misc_config_offset: r = {30'h0, equal_write_ignore_reg, 1'b0};
			channel_mode_offset: r = {21'h0, shadow_enable_reg, 2'h0, capture_source_select_reg};
			default: r = 32'h0000_0000;
		endcase
		read_mux = r;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ch1_value_offset) || (a == ch2_value_offset) ||
			(a == ch3_value_offset) || (a == burst_config_offset) ||
			(a == burst_window_offset) || (a == misc_config_offset) ||
			(a == channel_mode_offset);
	endfunction

	// write path: address and data held until both are present
	wire [7:0] aw_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	wire [31:0] w_data = w_held_reg ? w_data_reg : s_axi_wdata;
	wire aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
	wire w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
	wire write_fire = aw_have && w_have && !s_axi_bvalid;
	wire read_fire = s_axi_arvalid && s_axi_arready;
	wire write_window = (aw_addr[7:2] == burst_window_offset[7:2]);
	wire read_window = (s_axi_araddr[7:2] == burst_window_offset[7:2]);
	wire [7:0] window_addr = window_target(burst_start_index_reg, burst_index_reg);
	wire [7:0] write_addr = write_window ? window_addr : {aw_addr[7:2], 2'b00};
	wire [7:0] read_addr = read_window ? window_addr : {s_axi_araddr[7:2], 2'b00};
	// window into itself maps to nothing rather than recursing
	wire write_ok = is_mapped(write_addr) && (write_addr != burst_window_offset);
	wire read_ok = is_mapped(read_addr) && (read_addr != burst_window_offset);
	// both channels may touch the window at once; each is one burst step
	wire [1:0] window_steps = {1'b0, write_fire && write_window} +
		{1'b0, read_fire && read_window};
	wire [4:0] burst_index_next;
	assign burst_index_next = (window_steps == 2'd0) ? burst_index_reg :
		(burst_index_reg >= burst_count_reg) ? 5'h00 :
		(burst_index_reg + 5'(window_steps) > burst_count_reg) ? 5'h00 :
		burst_index_reg + 5'(window_steps);

	wire [2:0] ch_hit;
	wire [2:0] ch_write;
	wire [2:0] input_mode;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : chan
			assign input_mode[g] = capture_source_select_reg[2*g +: 2] != 2'h0;
			assign ch_hit[g] = write_fire && write_ok &&
				(write_addr == ch1_value_offset + 8'(4 * g));
			// equal data is dropped when asked to
			assign ch_write[g] = ch_hit[g] &&
				!(equal_write_ignore_reg && w_data[15:0] == value_bus[g]);
			ccv_channel channel (
				.clk(clk),
				.reset_n(reset_n),
				.input_mode(input_mode[g]),
				.shadow_enable(shadow_enable_reg[g]),
				.update_event(update_event),
				.capture_event(capture_event[g]),
				.counter_value(counter_value),
				.write_strobe(ch_write[g]),
				.write_value(w_data[15:0]),
				.value_reg(value_bus[g]),
				.compare_reg(compare_bus[g])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ch1_compare_reg <= reg_reset_value[15:0];
			ch2_compare_reg <= reg_reset_value[15:0];
			ch3_compare_reg <= reg_reset_value[15:0];
		end else begin
			ch1_compare_reg <= compare_bus[0];
			ch2_compare_reg <= compare_bus[1];
			ch3_compare_reg <= compare_bus[2];
		end
	end

	// axi handshake registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= axi_resp_okay;
		end else begin
			s_axi_awready <= !aw_have && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_have && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
			end
			aw_held_reg <= aw_have && !write_fire;
			w_held_reg <= w_have && !write_fire;
			if (write_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= write_ok ? axi_resp_okay : axi_resp_slverr;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= reg_reset_value;
			s_axi_rresp <= axi_resp_okay;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !read_fire;
			if (read_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_mux(read_addr);
				s_axi_rresp <= read_ok ? axi_resp_okay : axi_resp_slverr;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// configuration registers; counts above the limit are clipped to it
	wire cfg_write = write_fire && write_ok && write_addr == burst_config_offset;
	wire [4:0] count_field = w_data[burst_count_lsb +: 5];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			burst_count_reg <= reg_reset_value[4:0];
			burst_start_index_reg <= reg_reset_value[4:0];
			burst_index_reg <= reg_reset_value[4:0];
			equal_write_ignore_reg <= reg_reset_value[0];
			capture_source_select_reg <= reg_reset_value[5:0];
			shadow_enable_reg <= reg_reset_value[2:0];
		end else begin
			burst_index_reg <= cfg_write ? 5'h00 : burst_index_next;
			if (cfg_write) begin
				burst_count_reg <= (count_field > burst_count_max) ?
					burst_count_max : count_field;
				burst_start_index_reg <= w_data[burst_start_lsb +: 5];
			end
			if (write_fire && write_ok && write_addr == misc_config_offset) begin
				equal_write_ignore_reg <= w_data[equal_ignore_bit];
			end
			if (write_fire && write_ok && write_addr == channel_mode_offset) begin
				capture_source_select_reg <= w_data[5:0];
				shadow_enable_reg <= w_data[shadow_enable_lsb +: 3];
			end
		end
	end

	a_burst_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		(window_steps != 2'd0) && !cfg_write && burst_index_reg == burst_count_reg
		|=> burst_index_reg == 5'h00)
		else $error("burst index did not return to zero");
	a_burst_step: assert property (@(posedge clk) disable iff (!reset_n)
		(window_steps == 2'd1) && !cfg_write && burst_index_reg < burst_count_reg
		|=> burst_index_reg == $past(burst_index_reg) + 5'h01)
		else $error("burst index did not advance");
	a_index_bound: assert property (@(posedge clk) disable iff (!reset_n)
		burst_index_reg <= burst_count_reg && burst_count_reg <= burst_count_max)
		else $error("burst index past count");
	a_equal_drop: assert property (@(posedge clk) disable iff (!reset_n)
		ch_hit[0] && equal_write_ignore_reg && w_data[15:0] == value_bus[0] |-> !ch_write[0])
		else $error("equal write not dropped");
	a_write_ack: assert property (@(posedge clk) disable iff (!reset_n)
		write_fire |=> s_axi_bvalid)
		else $error("write not answered");
	a_read_ack: assert property (@(posedge clk) disable iff (!reset_n)
		read_fire |=> s_axi_rvalid)
		else $error("read not answered");
	// an answer is given once; a second one would look like another access
	a_write_answer_once: assert property (@(posedge clk) disable iff (!reset_n)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_read_answer_once: assert property (@(posedge clk) disable iff (!reset_n)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_write_error: assert property (@(posedge clk) disable iff (!reset_n)
		write_fire && !write_ok |=> s_axi_bresp == axi_resp_slverr)
		else $error("unmapped write not refused");
	a_read_error: assert property (@(posedge clk) disable iff (!reset_n)
		read_fire && !read_ok
		|=> s_axi_rresp == axi_resp_slverr && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	// window targets are checked against the start word, not through the address helper
	sequence window_write_s;
		write_fire && write_window;
	endsequence
	sequence window_read_s;
		read_fire && read_window;
	endsequence
	sequence burst_first_s;
		burst_index_reg == 5'h00;
	endsequence
	sequence burst_second_s;
		burst_index_reg == 5'h01;
	endsequence
	a_first_write_target: assert property (@(posedge clk) disable iff (!reset_n)
		window_write_s ##0 burst_first_s
		|-> write_addr == {1'b0, burst_start_index_reg, 2'b00})
		else $error("first window write reached the wrong register");
	a_second_write_target: assert property (@(posedge clk) disable iff (!reset_n)
		window_write_s ##0 burst_second_s
		|-> write_addr == {1'b0, burst_start_index_reg, 2'b00} + 8'h04)
		else $error("second window write reached the wrong register");
	a_first_read_target: assert property (@(posedge clk) disable iff (!reset_n)
		window_read_s ##0 burst_first_s
		|-> read_addr == {1'b0, burst_start_index_reg, 2'b00})
		else $error("first window read reached the wrong register");
	a_second_read_target: assert property (@(posedge clk) disable iff (!reset_n)
		window_read_s ##0 burst_second_s
		|-> read_addr == {1'b0, burst_start_index_reg, 2'b00} + 8'h04)
		else $error("second window read reached the wrong register");
	// a new configuration starts the next burst at the start word
	a_config_restart: assert property (@(posedge clk) disable iff (!reset_n)
		cfg_write |=> burst_index_reg == 5'h00)
		else $error("configuration write did not restart the burst");
	a_input_write_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		ch_hit[1] && input_mode[1] && !capture_event[1]
		|=> value_bus[1] == $past(value_bus[1]))
		else $error("input channel took a software write");
	// the output register adds one edge after the update edge
	a_shadow_output: assert property (@(posedge clk) disable iff (!reset_n)
		update_event && !input_mode[0] && shadow_enable_reg[0]
		|-> ##2 ch1_compare_reg == $past(value_bus[0]))
		else $error("update did not load the channel 1 compare output");
endmodule

// [hw/timer_ccv_pkg.sv]
/*
 * constants for the capture/compare value and burst window register block.
 * assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package timer_ccv_pkg;
	localparam logic [7:0] ch1_value_offset = 8'h38;
	localparam logic [7:0] ch2_value_offset = 8'h3C;
	localparam logic [7:0] ch3_value_offset = 8'h40;
	localparam logic [7:0] burst_config_offset = 8'h48;
	localparam logic [7:0] burst_window_offset = 8'h4C;
	localparam logic [7:0] misc_config_offset = 8'hFC;
	localparam logic [7:0] channel_mode_offset = 8'hF0;
	localparam logic [31:0] reg_reset_value = 32'h0000_0000;
	localparam int burst_count_lsb = 8;
	localparam int burst_start_lsb = 0;
	localparam int equal_ignore_bit = 1;
	localparam int shadow_enable_lsb = 8;
	localparam logic [4:0] burst_count_max = 5'h11;
	localparam logic [1:0] axi_resp_okay = 2'h0;
	localparam logic [1:0] axi_resp_slverr = 2'h2;
	typedef enum logic [2:0] {
		wr_idle_type = 3'b001,
		wr_resp_type = 3'b010,
		wr_hold_type = 3'b100
	} write_state_type;
endpackage

// [hw/ccv_channel.sv]
/*
 * one capture/compare channel: preload value, active compare value, capture.
 * assumes capture and update strobes are one-cycle pulses in the clk domain.
 */
`timescale 1ns/1ns
module ccv_channel (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic input_mode,
	input wire logic shadow_enable,
	input wire logic update_event,
	input wire logic capture_event,
	input wire logic [15:0] counter_value,
	// software write
	input wire logic write_strobe,
	input wire logic [15:0] write_value,
	// results
	output logic [15:0] value_reg,
	output logic [15:0] compare_reg
);
	import timer_ccv_pkg::*;
	logic [15:0] value_next;
	logic [15:0] compare_next;
	wire sw_write = write_strobe && !input_mode;

	assign value_next = (input_mode && capture_event) ? counter_value :
		sw_write ? write_value : value_reg;
	// without shadowing the compare value follows every write at once
	assign compare_next = input_mode ? compare_reg :
		(!shadow_enable || update_event) ? value_next : compare_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			value_reg <= reg_reset_value[15:0];
			compare_reg <= reg_reset_value[15:0];
		end else begin
			value_reg <= value_next;
			compare_reg <= compare_next;
		end
	end

	a_input_readonly: assert property (@(posedge clk) disable iff (!reset_n)
		input_mode && !capture_event |=> value_reg == $past(value_reg))
		else $error("input channel value changed without capture");
	a_capture_latch: assert property (@(posedge clk) disable iff (!reset_n)
		input_mode && capture_event |=> value_reg == $past(counter_value))
		else $error("capture did not latch counter");
	a_shadow_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!input_mode && shadow_enable && !update_event |=> $stable(compare_reg))
		else $error("shadowed compare changed outside update");
	a_direct_compare: assert property (@(posedge clk) disable iff (!reset_n)
		!input_mode && !shadow_enable |=> compare_reg == value_reg)
		else $error("compare does not follow value");
endmodule

// [verification/axi_lite_master.sv]
/*
 AXI4-Lite master standing in for the processor bus and the burst engine.
 assumes the slave answers in its own time; only the bench watchdog ends a wait.
*/
`timescale 1ns/1ns
module axi_lite_master (
	// clock
	input wire logic clk,
	// write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	task automatic write_word(input logic [7:0] addr, input logic [31:0] data,
		output logic [1:0] resp);
		@(posedge clk);
		awaddr <= addr;
		wdata <= data;
		// only whole words go out
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic read_word(input logic [7:0] addr, output logic [31:0] data,
		output logic [1:0] resp);
		@(posedge clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
endmodule

// [verification/timer_ccv_regs_tb.sv]
/*
 self-checking bench for the capture/compare value and burst window registers.
 assumes the bus master model drives the register bus; the bench drives the core strobes.
*/
`timescale 1ns/1ns
module timer_ccv_regs_tb;
	import timer_ccv_pkg::*;
	logic clk;
	logic reset_n;
	logic update_event;
	logic [2:0] capture_event;
	logic [15:0] counter_value;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [15:0] cmp1, cmp2, cmp3;
	int fails;
	int comparisons;
	timer_ccv_regs timer_ccv_regs_inst (.clk(clk), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .update_event(update_event),
		.capture_event(capture_event), .counter_value(counter_value),
		.ch1_compare_reg(cmp1), .ch2_compare_reg(cmp2), .ch3_compare_reg(cmp3));
	axi_lite_master axi_lite_master_inst (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] er);
		logic [1:0] resp;
		axi_lite_master_inst.write_word(addr, data, resp);
		check($sformatf("bresp %h", addr), {30'h0, er}, {30'h0, resp});
	endtask
	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] data;
		logic [1:0] resp;
		axi_lite_master_inst.read_word(addr, data, resp);
		check($sformatf("rdata %h", addr), exp, data);
		check($sformatf("rresp %h", addr), {30'h0, er}, {30'h0, resp});
	endtask
	// one-cycle strobes, then time for the trailing compare outputs to settle
	task automatic pulse(input logic upd, input logic [2:0] cap, input logic [15:0] cnt);
		@(posedge clk);
		update_event <= upd;
		capture_event <= cap;
		counter_value <= cnt;
		@(posedge clk);
		update_event <= 1'b0;
		capture_event <= 3'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic test_reset_values();
		rd(ch1_value_offset, 32'h0000_0000, axi_resp_okay);
		rd(ch2_value_offset, 32'h0000_0000, axi_resp_okay);
		rd(ch3_value_offset, 32'h0000_0000, axi_resp_okay);
		rd(burst_config_offset, 32'h0000_0000, axi_resp_okay);
		rd(misc_config_offset, 32'h0000_0000, axi_resp_okay);
	endtask
	task automatic test_burst();
		// start word 0x0E reaches the channel 1 value, count 2 gives three accesses
		wr(burst_config_offset, 32'h0000_020E, axi_resp_okay);
		wr(burst_window_offset, 32'h0000_1111, axi_resp_okay);
		wr(burst_window_offset, 32'h0000_2222, axi_resp_okay);
		wr(burst_window_offset, 32'h0000_3333, axi_resp_okay);
		wr(burst_window_offset, 32'h0000_4444, axi_resp_okay);
		rd(ch1_value_offset, 32'h0000_4444, axi_resp_okay);
		rd(ch2_value_offset, 32'h0000_2222, axi_resp_okay);
		rd(ch3_value_offset, 32'h0000_3333, axi_resp_okay);
		pulse(1'b0, 3'h0, 16'h0000);
		check("ch2 compare", 32'h0000_2222, {16'h0, cmp2});
		check("ch3 compare", 32'h0000_3333, {16'h0, cmp3});
		wr(burst_config_offset, 32'h0000_020F, axi_resp_okay);
		rd(burst_window_offset, 32'h0000_2222, axi_resp_okay);
		rd(burst_window_offset, 32'h0000_3333, axi_resp_okay);
	endtask
	task automatic test_equal_ignore();
		wr(misc_config_offset, 32'h0000_0002, axi_resp_okay);
		rd(misc_config_offset, 32'h0000_0002, axi_resp_okay);
		wr(ch1_value_offset, 32'h0000_5555, axi_resp_okay);
		wr(ch1_value_offset, 32'h0000_5555, axi_resp_okay);
		rd(ch1_value_offset, 32'h0000_5555, axi_resp_okay);
	endtask
	task automatic test_shadow();
		wr(channel_mode_offset, 32'h0000_0100, axi_resp_okay);
		wr(ch1_value_offset, 32'h0000_6666, axi_resp_okay);
		pulse(1'b0, 3'h0, 16'h0000);
		check("ch1 compare held", 32'h0000_5555, {16'h0, cmp1});
		pulse(1'b1, 3'h0, 16'h0000);
		check("ch1 compare loaded", 32'h0000_6666, {16'h0, cmp1});
	endtask
	task automatic test_input_mode();
		wr(channel_mode_offset, 32'h0000_0104, axi_resp_okay);
		wr(ch2_value_offset, 32'h0000_7777, axi_resp_okay);
		rd(ch2_value_offset, 32'h0000_2222, axi_resp_okay);
		pulse(1'b0, 3'h2, 16'hBEEF);
		rd(ch2_value_offset, 32'h0000_BEEF, axi_resp_okay);
		rd(ch1_value_offset, 32'h0000_6666, axi_resp_okay);
	endtask
	task automatic test_unmapped();
		wr(8'h10, 32'h0000_ABCD, axi_resp_slverr);
		rd(8'h10, 32'h0000_0000, axi_resp_slverr);
	endtask
	initial begin
		fails = 0;
		comparisons = 0;
		reset_n = 1'b0;
		update_event = 1'b0;
		capture_event = 3'h0;
		counter_value = 16'h0000;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		test_reset_values();
		test_burst();
		test_equal_ignore();
		test_shadow();
		test_input_mode();
		test_unmapped();
		end_of_test();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		fails++;
		end_of_test();
	end
endmodule
